// ==== simsample_adc_conv_config_bench.sv ====
`timescale 1ns/1ps
module simsample_adc_conv_config_bench
  import ssadc_pkg::*;
;
  logic sys_clk, rst_n, ce, refSelStrap, psel, penable, pwrite, pready, pslverr, busy, e;
  logic refIntEnable, refBufEnable, analogEnable, rangeHigh, standby, shutdown;
  logic [1:0] ifaceMode;
  logic [7:0] paddr, trackHold;
  logic [31:0] pwdata, prdata, r;
  logic [7:0][15:0] adcSample;
  logic [15:0] res [8];
  logic [15:0] pend [8];
  int mismatches, checksDone, n;

  // free running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  ssadc_conv_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .refSelStrap(refSelStrap),
    .adcSample(adcSample), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
    .trackHold(trackHold), .refIntEnable(refIntEnable), .refBufEnable(refBufEnable),
    .analogEnable(analogEnable), .rangeHigh(rangeHigh), .standby(standby), .shutdown(shutdown),
    .ifaceMode(ifaceMode));

  ssadc_host host (.sys_clk(sys_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // register access shorthands
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r, e);
  endtask : wr

  // ratio code is picked up while the device reset bit is set
  task automatic setos(input logic [2:0] c);
    wr(CFG_OFFS, {24'h0, 8'h28 | {5'h0, c}});
    wr(CTRL_OFFS, 32'h4);
    wr(CTRL_OFFS, 32'h0);
  endtask : setos

  // new random samples, remembered for all eight channels whatever m holds
  task automatic newsamp(input logic [7:0] m);
    logic [15:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = 16'($urandom());
      adcSample[i] <= v;
      pend[i] = v;
    end
  endtask : newsamp

  // model publishes the converted groups, then all results are read back
  task automatic pubcheck(input logic [7:0] m);
    for (int i = 0; i < 8; i++)
    begin
      if (m[i])
        res[i] = pend[i];
      rd(DATA_OFFS + 8'(4 * i));
      chk(r & 32'hffff, {16'h0, res[i]});
    end
  endtask : pubcheck

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // hang guard, about twice the longest expected run
  initial
  begin
    #1600us;
    mismatches++;
    stop_test();
  end

  // main sequence
  initial
  begin
    logic p, rs, rg, f, b, shd;
    logic [1:0] im;
    int ratio;
    rst_n = 1'b0;
    ce = 1'b1;
    refSelStrap = 1'b1;
    adcSample = '0;
    mismatches = 0;
    checksDone = 0;
    foreach (res[i]) res[i] = 16'h0;
    void'($urandom(47478));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({busy, trackHold, standby, shutdown, analogEnable, rangeHigh, ifaceMode}, 32'h8);
    rd(CFG_OFFS);
    chk(r, 32'h28);
    chk({refIntEnable, refBufEnable}, 32'h3);
    rd(8'h40);
    chk({r[30:0], e}, 32'h1);
    $display("test reset done");
    // every combination of the mode straps
    for (int i = 0; i < 32; i++)
    begin
      wr(CFG_OFFS, {24'h0, i[4:0], 3'h0});
      #1;
      {b, f, p, rg, rs} = i[4:0];
      shd = !p && !rg;
      im = f ? (b ? IFACE_BYTE : IFACE_SER) : IFACE_PAR;
      chk({ifaceMode, rangeHigh, standby, shutdown, analogEnable}, {im, rg, !p && rg, shd, p});
      if (!shd)
        chk({refIntEnable, refBufEnable}, {rs, 1'b1});
      rd(STAT_OFFS);
      chk({r[9:8], r[5:4]}, {im, shd, !p && rg});
    end
    $display("test modes done");
    // every ratio code with its busy length
    for (int c = 0; c < 8; c++)
    begin
      setos(c[2:0]);
      newsamp(8'hff);
      wr(CTRL_OFFS, 32'h3);
      host.waitdone(n);
      ratio = (c == 0 || c == 7) ? 1 : (1 << c);
      chk(n, ratio * SAMPLE_CYCLES + 1);
      rd(STAT_OFFS);
      chk(r[3:1], c);
      pubcheck(8'hff);
    end
    $display("test ratios done");
    // one group at a time, read while busy, ratio changed mid-run
    setos(3'h0);
    newsamp(8'h0f);
    wr(CTRL_OFFS, 32'h1);
    rd(DATA_OFFS);
    chk(trackHold, 32'h0f);
    chk(r & 32'hffff, {16'h0, res[0]});
    wr(CFG_OFFS, 32'h2b);
    host.waitdone(n);
    pubcheck(8'h0f);
    rd(STAT_OFFS);
    chk(r[3:1], 32'h3);
    newsamp(8'hf0);
    wr(CTRL_OFFS, 32'h2);
    host.waitdone(n);
    chk(n, 8 * SAMPLE_CYCLES + 1);
    pubcheck(8'hf0);
    $display("test groups done");
    // start refused in shutdown, device reset cuts a conversion
    wr(CFG_OFFS, 32'h08);
    wr(CTRL_OFFS, 32'h3);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(busy, 32'h0);
    wr(CTRL_OFFS, 32'h0);
    wr(CFG_OFFS, 32'h28);
    wr(CTRL_OFFS, 32'h3);
    repeat (5) @(posedge sys_clk);
    #1;
    chk({busy, trackHold}, 32'h1ff);
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk({busy, trackHold, pready}, 32'h3fe);
    @(posedge sys_clk);
    ce <= 1'b1;
    wr(CTRL_OFFS, 32'h7);
    #1;
    chk(busy, 32'h0);
    wr(CTRL_OFFS, 32'h0);
    $display("test refusal done");
    // second reset with the reference strap low
    @(posedge sys_clk);
    rst_n <= 1'b0;
    refSelStrap <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(CFG_OFFS);
    chk(r, 32'h20);
    chk({refIntEnable, refBufEnable}, 32'h1);
    $display("test strap done");
    stop_test();
  end
endmodule : simsample_adc_conv_config_bench

// ==== ssadc_acc_if.sv ====
`timescale 1ns/1ps
interface ssadc_acc_if #(parameter int CH = 8, parameter int DW = 16);
  logic ce;
  logic clear;
  logic add;
  logic finish;
  logic [2:0] osLog;
  logic [CH-1:0] mask;
  logic [CH-1:0][DW-1:0] sample;
  logic [CH-1:0][DW-1:0] result;
  modport ctl (output ce, clear, add, finish, osLog, mask, sample, input result);
  modport acc (input ce, clear, add, finish, osLog, mask, sample, output result);
endinterface : ssadc_acc_if

// ==== ssadc_accum.sv ====
`timescale 1ns/1ps
module ssadc_accum
  import ssadc_pkg::*;
#(
  parameter int CH = 8,
  parameter int DW = 16,
  parameter int AW = 22
)
(
  input wire logic sys_clk, // system clock
  input wire logic rst_n,   // sync reset
  ssadc_acc_if.acc bus      // accumulate control
);
  genvar i;
  generate
    for (i = 0; i < CH; i++)
    begin : g_ch
      logic signed [AW-1:0] sum;
      logic [DW-1:0] res;
      // running sum of the held channel, then averaged by shift
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          sum <= '0;
          res <= '0;
        end
        else if (bus.ce)
        begin
          if (bus.clear)
            sum <= '0;
          else if (bus.add && bus.mask[i])
            sum <= sum + AW'(signed'(bus.sample[i]));
          if (bus.finish && bus.mask[i])
            res <= DW'(sum >>> bus.osLog);
        end
      end
      assign bus.result[i] = res;
    end
  endgenerate
endmodule : ssadc_accum

// ==== ssadc_conv_ctrl.sv ====
// Contract
// - codes 1-6 pick ratio 2 to 64
// - codes 0 and 7 mean no averaging
// - average samples, one word per channel
// - results are 16-bit two's complement
// - reference select high enables internal reference
// - select low powers internal reference down
// - reference buffer stays enabled either way
// - power-up reference mode follows strap level
// - range high 10 V, low 5 V
// - power-down low leaves normal operation
// - range picks standby or shutdown
// - shutdown all off, standby keeps reference
// - interface high: byte or serial by byte
// - both low gives full parallel
// - start one covers 1-4, two covers 5-8
// - start rise holds and converts group
// - results readable at any time
// - reset bit holds device in reset
// - ratio latched at busy fall
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ssadc_conv_ctrl
  import ssadc_pkg::*;
#(
  parameter int CH = 8,
  parameter int DW = 16
)
(
  input wire logic sys_clk,                    // 25 mhz clock
  input wire logic rst_n,                      // sync reset
  input wire logic ce,                         // clock enable
  input wire logic refSelStrap,                // reference strap level
  input wire logic [CH-1:0][DW-1:0] adcSample, // raw sar codes
  input wire logic psel,                       // apb select
  input wire logic penable,                    // apb enable
  input wire logic pwrite,                     // apb direction
  input wire logic [7:0] paddr,                // apb address
  input wire logic [31:0] pwdata,              // apb write data
  output logic [31:0] prdata,                  // apb read data
  output logic pready,                         // apb ready
  output logic pslverr,                        // apb error
  output logic busy,                           // conversion running
  output logic [CH-1:0] trackHold,             // channel in hold
  output logic refIntEnable,                   // internal reference on
  output logic refBufEnable,                   // reference buffer on
  output logic analogEnable,                   // front end powered
  output logic rangeHigh,                      // 10 v range
  output logic standby,                        // standby state
  output logic shutdown,                       // shutdown state
  output logic [1:0] ifaceMode                 // read interface mode
);
  localparam int HALF = CH / 2;

  logic [7:0] cfg;
  logic [2:0] ctrl;
  logic strapTaken;
  logic grp1Prev;
  logic grp2Prev;
  logic [2:0] osActive;
  logic [2:0] osLog;
  logic [6:0] ratioM1;
  ssadc_state_t state;
  logic [7:0] cycCnt;
  logic [6:0] smpCnt;
  logic [CH-1:0] holdMask;
  logic [13:0] busyLen;
  logic devReset;
  logic powerDown;
  logic rise1;
  logic rise2;
  logic canConv;
  logic slotEnd;
  logic apbWrite;
  logic apbSetup;
  logic mapped;
  logic [31:0] next_prdata;

  ssadc_acc_if #(.CH(CH), .DW(DW)) accBus ();

  ssadc_os_decode u_dec (
    .osCode(osActive),
    .osLog(osLog),
    .ratioM1(ratioM1)
  );

  ssadc_accum #(.CH(CH), .DW(DW), .AW(DW + 6)) u_acc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus(accBus)
  );

  // decoded pin levels
  assign devReset = ctrl[CTRL_RST_BIT];
  assign powerDown = !cfg[CFG_PDN_BIT];
  assign rise1 = ctrl[CTRL_GRP1_BIT] && !grp1Prev;
  assign rise2 = ctrl[CTRL_GRP2_BIT] && !grp2Prev;
  assign canConv = !powerDown && !devReset;
  assign slotEnd = (state == ST_CONV) && (cycCnt == 8'(SAMPLE_CYCLES - 1));

  // power, range and reference outputs
  assign standby = powerDown && cfg[CFG_RANGE_BIT];
  assign shutdown = powerDown && !cfg[CFG_RANGE_BIT];
  assign analogEnable = !powerDown;
  assign refIntEnable = cfg[CFG_REF_BIT] && !shutdown;
  assign refBufEnable = !shutdown;
  assign rangeHigh = cfg[CFG_RANGE_BIT];

  // read interface selection
  always_comb
  begin
    if (!cfg[CFG_IFACE_BIT])
      ifaceMode = IFACE_PAR;
    else if (cfg[CFG_BYTE_BIT])
      ifaceMode = IFACE_BYTE;
    else
      ifaceMode = IFACE_SER;
  end

  // apb decode
  assign apbWrite = psel && penable && pwrite && ce;
  assign apbSetup = psel && !penable && ce;
  assign pready = ce;
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr == CFG_OFFS) || (paddr == CTRL_OFFS) || (paddr == STAT_OFFS)
                  || (paddr >= DATA_OFFS && paddr < DATA_OFFS + 8'(4 * CH)));
  assign pslverr = psel && penable && !mapped;

  // configuration register, reference level caught once after reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg <= CFG_RESET;
      strapTaken <= 1'b0;
    end
    else if (ce)
    begin
      if (!strapTaken)
      begin
        cfg[CFG_REF_BIT] <= refSelStrap;
        strapTaken <= 1'b1;
      end
      else if (apbWrite && paddr == CFG_OFFS)
        cfg <= pwdata[7:0];
    end
  end

  // control register with start levels and device reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ctrl <= CTRL_RESET;
    else if (ce && apbWrite && paddr == CTRL_OFFS)
      ctrl <= pwdata[2:0];
  end

  // start level history for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      grp1Prev <= 1'b0;
      grp2Prev <= 1'b0;
    end
    else if (ce)
    begin
      grp1Prev <= ctrl[CTRL_GRP1_BIT];
      grp2Prev <= ctrl[CTRL_GRP2_BIT];
    end
  end

  // read mux, captured in the setup phase
  always_comb
  begin
    next_prdata = 32'h0;
    if (paddr == CFG_OFFS)
      next_prdata[7:0] = cfg;
    else if (paddr == CTRL_OFFS)
      next_prdata[2:0] = ctrl;
    else if (paddr == STAT_OFFS)
    begin
      next_prdata[STAT_BUSY_BIT] = busy;
      next_prdata[STAT_OS_LSB +: 3] = osActive;
      next_prdata[STAT_POWER_DOWN_N_BIT] = standby;
      next_prdata[STAT_SHDN_BIT] = shutdown;
      next_prdata[STAT_REFINT_BIT] = refIntEnable;
      next_prdata[STAT_REFBUF_BIT] = refBufEnable;
      next_prdata[STAT_IFACE_LSB +: 2] = ifaceMode;
    end
    else if (mapped)
      next_prdata[DW-1:0] = accBus.result[3'((paddr - DATA_OFFS) >> 2)];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      prdata <= 32'h0;
    else if (apbSetup)
      prdata <= next_prdata;
  end

  // conversion sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cycCnt <= 8'h0;
      smpCnt <= 7'h0;
      holdMask <= '0;
    end
    else if (ce)
    begin
      if (devReset)
      begin
        state <= ST_IDLE;
        holdMask <= '0;
      end
      else
      begin
        unique case (state)
          ST_IDLE:
          begin
            if ((rise1 || rise2) && canConv)
            begin
              state <= ST_CONV;
              holdMask <= {{HALF{rise2}}, {HALF{rise1}}};
              cycCnt <= 8'h0;
              smpCnt <= 7'h0;
            end
          end
          ST_CONV:
          begin
            if (slotEnd)
            begin
              cycCnt <= 8'h0;
              if (smpCnt == ratioM1)
                state <= ST_FINISH;
              else
                smpCnt <= smpCnt + 7'h1;
            end
            else
              cycCnt <= cycCnt + 8'h1;
          end
          ST_FINISH:
          begin
            state <= ST_IDLE;
            holdMask <= '0;
          end
        endcase
      end
    end
  end

  // busy spans every sample slot plus the result transfer
  assign busy = (state != ST_IDLE) && !devReset;
  assign trackHold = holdMask;

  // ratio taken when busy falls, and re-read while in reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      osActive <= OS_NONE_LO;
    else if (ce && (devReset || (state == ST_FINISH)))
      osActive <= cfg[CFG_OS_LSB +: 3];
  end

  // busy length counter, read only by the checks below
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      busyLen <= 14'h0;
    else if (ce)
    begin
      if (state == ST_IDLE)
        busyLen <= 14'h1;
      else
        busyLen <= busyLen + 14'h1;
    end
  end

  // accumulator control
  assign accBus.ce = ce;
  assign accBus.clear = (state == ST_IDLE);
  assign accBus.add = slotEnd;
  assign accBus.finish = (state == ST_FINISH);
  assign accBus.osLog = osLog;
  assign accBus.mask = holdMask;
  assign accBus.sample = adcSample;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n || !ce);

  sequence s_start1;
    (state == ST_IDLE) && rise1 && canConv && !rise2;
  endsequence

  sequence s_hold1;
    busy && trackHold == {{HALF{1'b0}}, {HALF{1'b1}}};
  endsequence

  AST_OS_LENGTH: assert property ((state == ST_FINISH) && osLog != 3'h0 && ce
    |-> busyLen == 14'((32'(ratioM1) + 1) * SAMPLE_CYCLES + 1))
    else $error("busy length does not match oversampling ratio");
  AST_NO_OS: assert property ((state == ST_FINISH) && (osActive == OS_NONE_LO || osActive == OS_NONE_HI)
    |-> busyLen == 14'(SAMPLE_CYCLES + 1))
    else $error("busy length wrong without oversampling");
  AST_REF_SEL: assert property (refIntEnable
    == (cfg[CFG_REF_BIT] && (cfg[CFG_PDN_BIT] || cfg[CFG_RANGE_BIT])))
    else $error("internal reference not following select");
  AST_REF_BUF: assert property (refBufEnable == (cfg[CFG_PDN_BIT] || cfg[CFG_RANGE_BIT])
    && analogEnable == cfg[CFG_PDN_BIT])
    else $error("reference buffer off outside shutdown");
  AST_PD_KIND: assert property (!cfg[CFG_PDN_BIT] |-> (standby == rangeHigh) && (shutdown != rangeHigh))
    else $error("power-down kind not chosen by range");
  AST_IFACE: assert property (!cfg[CFG_IFACE_BIT] && !cfg[CFG_BYTE_BIT] |-> ifaceMode == IFACE_PAR)
    else $error("interface mode wrong");
  AST_START: assert property (s_start1 ##1 !devReset |-> s_hold1)
    else $error("group one start did not hold channels 1-4");
  AST_RESET: assert property (devReset |=> !busy && state == ST_IDLE)
    else $error("reset did not stop conversion");
  AST_OS_LATCH: assert property ((state == ST_FINISH) && !devReset |=> osActive == $past(cfg[CFG_OS_LSB +: 3]))
    else $error("ratio not latched at busy fall");
  AST_BUSY_FALL: assert property ($fell(busy) && !devReset |-> $past(state) == ST_FINISH)
    else $error("busy fell before results were stored");

  // both groups started together hold all eight channels
  sequence s_startBoth;
    (state == ST_IDLE) && rise1 && rise2 && canConv;
  endsequence

  AST_START_BOTH: assert property (s_startBoth ##1 !devReset |-> busy && trackHold == {CH{1'b1}})
    else $error("joint start did not hold every channel");

  // stored results only move when a conversion completes
  AST_DATA_STAND: assert property (!accBus.finish |=> $stable(accBus.result))
    else $error("result changed outside a conversion end");

  // power-down states switch off the front end, and the reference buffer in shutdown only
  AST_PD_POWER: assert property (!cfg[CFG_PDN_BIT]
    |-> !analogEnable && (refBufEnable == cfg[CFG_RANGE_BIT]))
    else $error("power-down did not switch the right circuits");

  // a low clock enable freezes the sequencer, its counters and the settings
  AST_CE_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n) !ce
    |=> state == $past(state) && cycCnt == $past(cycCnt) && smpCnt == $past(smpCnt) && cfg == $past(cfg))
    else $error("state moved while clock enable was low");
endmodule : ssadc_conv_ctrl

// ==== ssadc_host.sv ====
`timescale 1ns/1ps
module ssadc_host
  import ssadc_pkg::*;
(
  input wire logic sys_clk,       // system clock
  input wire logic pready,        // apb ready
  input wire logic [31:0] prdata, // apb read data
  input wire logic pslverr,       // apb error
  input wire logic busy,          // conversion running
  output logic psel,              // apb select
  output logic penable,           // apb enable
  output logic pwrite,            // apb direction
  output logic [7:0] paddr,       // apb address
  output logic [31:0] pwdata      // apb write data
);
  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer, request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // counts busy cycles, start bits dropped only once busy has ended
  task automatic waitdone(output int n);
    int k;
    logic [31:0] r;
    logic e;
    n = 0;
    k = 0;
    while (busy !== 1'b1 && k < 8)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    while (busy === 1'b1 && n < 20000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    xfer(1'b1, CTRL_OFFS, 32'h0, r, e);
  endtask : waitdone
endmodule : ssadc_host

// ==== ssadc_os_decode.sv ====
`timescale 1ns/1ps
module ssadc_os_decode
  import ssadc_pkg::*;
(
  input wire logic [2:0] osCode, // oversample code
  output logic [2:0] osLog,      // log2 of ratio
  output logic [6:0] ratioM1     // ratio minus one
);
  // codes 1..6 give ratio 2**code, the two outer codes give no averaging
  always_comb
  begin
    if (osCode == OS_NONE_LO || osCode == OS_NONE_HI)
      osLog = 3'h0;
    else
      osLog = osCode;
    ratioM1 = 7'((8'h01 << osLog) - 8'h01);
  end
endmodule : ssadc_os_decode

// ==== ssadc_pkg.sv ====
package ssadc_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] CFG_OFFS = 8'h00;
  localparam logic [7:0] CTRL_OFFS = 8'h04;
  localparam logic [7:0] STAT_OFFS = 8'h08;
  localparam logic [7:0] DATA_OFFS = 8'h10;
  // configuration register fields
  localparam int CFG_OS_LSB = 0;
  localparam int CFG_REF_BIT = 3;
  localparam int CFG_RANGE_BIT = 4;
  localparam int CFG_PDN_BIT = 5;
  localparam int CFG_IFACE_BIT = 6;
  localparam int CFG_BYTE_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h20;
  // control register fields
  localparam int CTRL_GRP1_BIT = 0;
  localparam int CTRL_GRP2_BIT = 1;
  localparam int CTRL_RST_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OS_LSB = 1;
  localparam int STAT_POWER_DOWN_N_BIT = 4;
  localparam int STAT_SHDN_BIT = 5;
  localparam int STAT_REFINT_BIT = 6;
  localparam int STAT_REFBUF_BIT = 7;
  localparam int STAT_IFACE_LSB = 8;
  // oversampling codes that mean no averaging
  localparam logic [2:0] OS_NONE_LO = 3'h0;
  localparam logic [2:0] OS_NONE_HI = 3'h7;
  // interface mode encoding
  localparam logic [1:0] IFACE_PAR = 2'h0;
  localparam logic [1:0] IFACE_BYTE = 2'h1;
  localparam logic [1:0] IFACE_SER = 2'h2;
  // one sample slot at the full 200 ksps rate, least time rounded up
  localparam int CLK_PERIOD_NS = 40;
  localparam int SAMPLE_PERIOD_NS = 5000;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_FINISH} ssadc_state_t;
endpackage : ssadc_pkg
